// file: core/cpsr_params.svh
// Purpose: constants for the copper port status report block
// Assumes: APB byte addresses, 32-bit data words
// Notes:   status word printed at index 0x11, so byte address is four times it
`ifndef CPSR_PARAMS_SVH
`define CPSR_PARAMS_SVH

`define CPSR_IDX_STATUS      6'h11
`define CPSR_IDX_CTRL        6'h10
`define CPSR_IDX_POLPAIR     6'h15
`define CPSR_IDX_IRQ_STAT    6'h20
`define CPSR_IDX_IRQ_MASK    6'h21
`define CPSR_IDX_LINK_IN     6'h22

`define CPSR_SPD_1000        2'h2
`define CPSR_SPD_100         2'h1
`define CPSR_SPD_10          2'h0
`define CPSR_SPD_RST         2'h2
`define CPSR_XO_AUTO         2'h3
`define CPSR_XO_MDIX         2'h1
`define CPSR_XO_MDI          2'h0
`define CPSR_XO_RST          2'h3
`define CPSR_MDIX_RST        1'h1
`define CPSR_IRQ_W           4
`define CPSR_IRQ_PAGE        0
`define CPSR_IRQ_LINK        1
`define CPSR_IRQ_SPEED       2
`define CPSR_IRQ_RESOLVED    3

`define CPSR_ADDR_IDX_HI     7
`define CPSR_ADDR_IDX_LO     2
`define CPSR_ST_W            16
`define CPSR_ST_SPEED_HI     15
`define CPSR_ST_SPEED_LO     14
`define CPSR_ST_DUPLEX       13
`define CPSR_ST_PAGE         12
`define CPSR_ST_RESOLVED     11
`define CPSR_ST_LINK         10
`define CPSR_ST_TX_PAUSE     9
`define CPSR_ST_RX_PAUSE     8
`define CPSR_ST_MDIX         6
`define CPSR_ST_SLEEP        4
`define CPSR_ST_GLINK        3
`define CPSR_ST_POLARITY     1
`define CPSR_ST_JABBER       0
`define CPSR_CTRL_XO_HI      6
`define CPSR_CTRL_XO_LO      5
`define CPSR_CTRL_POLDIS     1
`define CPSR_PAIR_W          4

`endif

// file: core/cpsr_pkg.sv
// Purpose: types for the copper port status report block
// Assumes: constants live in cpsr_params.svh
// Notes:   the link view arrives from the negotiation engine as one struct
package cpsr_pkg;
  // live link view from the negotiation and line logic
  typedef struct packed {
    logic       an_enable;
    logic       an_complete;
    logic       page_rx;
    logic [1:0] speed;
    logic       full_duplex;
    logic       link_up;
    logic       tx_pause;
    logic       rx_pause;
    logic       mdix_auto;
    logic       energy_sleep;
    logic       pol_rev;
    logic [3:0] pair_pol;
    logic       jabber;
  } cpsr_link_t;

  // apb slave request carrier
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } cpsr_apb_req_t;
endpackage

// file: core/cpsr_status.sv
// Purpose: copper port status word with control, interrupt and apb access
// Assumes: pclk 125 MHz, presetn async active low, link inputs synchronous
// Notes:   sw_reset_i applies the staged crossover mode; status word read clears page flag
//          resolved is combinational, so it reads one at once when negotiation is off; forced speed shows a clock later
//          speed, duplex and pause are held from the last resolved cycle, so a pending
//          resolution never shows half-updated fields
//          read data is loaded in the setup cycle; the slave never adds wait states
//          unmapped offsets answer with pslverr, read zero and ignore writes
//          interrupt events: page, link change, speed change while resolved, resolved rising
//          a clearing write and a new event in one cycle keep the event
//          polarity reversal disable acts at once, unlike the crossover mode
//          a manual crossover mode drives the crossover bit whatever the resolution
//          the staged crossover mode reads back before it is applied
//          link and energy inputs are taken as already synchronous to pclk
//          page_rx is a one-cycle pulse from the negotiation engine
//          reserved status bits and unused upper word bits read zero
//          the interrupt output is a level, not a pulse
//          no counters: every answer is at most one cycle away
// How it works
// R1: speed field 10 gig, 01 hundred, 00 ten
// R2: resolved set on negotiation complete, else clear
// R3: negotiation disabled forces resolved to one
// R4: duplex bit one full, zero half
// R5: page flag latches high, clears on read
// R6: copper link bit is real time
// R7: pause bits mirror resolution, informational only
// R8: crossover bit one mdix, reset one
// R9: crossover mode applied only at software reset
// R10: global link bit mirrors copper link
// R11: polarity reversed bit, forced normal when disabled
// R12: gigabit shows per-pair polarity in own field
// R13: energy sleep and jabber real time, reset zero
`timescale 1ns/1ns
`include "cpsr_params.svh"

module cpsr_status (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire cpsr_pkg::cpsr_apb_req_t apb_req,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire cpsr_pkg::cpsr_link_t  link_i,
  input  wire logic                  sw_reset_i,
  output logic                       irq_o
);
  import cpsr_pkg::*;

  // bus decode
  logic        access;
  logic        wr_en;
  logic        rd_en;
  logic [5:0]  idx;
  logic        hit;
  logic        resolved;
  logic [15:0] status_word;
  logic [31:0] rd_word;

  // one select per mapped register
  logic        sel_status;
  logic        sel_ctrl;
  logic        sel_polpair;
  logic        sel_irq_stat;
  logic        sel_irq_mask;
  logic        rd_setup;
  logic        wr_ctrl;
  logic        wr_irq_stat;
  logic        wr_irq_mask;
  logic        rd_status;

  // status word fields
  logic [1:0]  fld_speed;
  logic        fld_duplex;
  logic        fld_page;
  logic        fld_resolved;
  logic        fld_link;
  logic        fld_tx_pause;
  logic        fld_rx_pause;
  logic        fld_mdix;
  logic        fld_sleep;
  logic        fld_glink;
  logic        fld_polarity;
  logic        fld_jabber;
  logic [3:0]  fld_pairs;

  // held control and status state
  logic [1:0]  xo_staged_q;
  logic [1:0]  xo_active_q;
  logic        pol_dis_q;
  logic        page_q;
  logic [1:0]  speed_q;
  logic        duplex_q;
  logic        tx_pause_q;
  logic        rx_pause_q;
  logic        mdix_q;
  logic        link_q;
  // interrupt state
  logic [`CPSR_IRQ_W-1:0] irq_stat_q;
  logic [`CPSR_IRQ_W-1:0] irq_mask_q;
  logic [`CPSR_IRQ_W-1:0] irq_ev;
  logic        prev_resolved_q;

  // single-cycle slave: answer in the access phase itself
  assign access  = apb_req.psel & apb_req.penable;
  assign wr_en   = access & apb_req.pwrite;
  assign rd_en   = access & ~apb_req.pwrite;
  assign idx     = apb_req.paddr[`CPSR_ADDR_IDX_HI:`CPSR_ADDR_IDX_LO];

  // zero wait: the access phase is its own answer
  assign pready  = access;
  assign pslverr = access & ~hit;

  // address decode; byte lanes below the word index are ignored
  assign sel_status   = (idx == `CPSR_IDX_STATUS);
  assign sel_ctrl     = (idx == `CPSR_IDX_CTRL);
  assign sel_polpair  = (idx == `CPSR_IDX_POLPAIR);
  assign sel_irq_stat = (idx == `CPSR_IDX_IRQ_STAT);
  assign sel_irq_mask = (idx == `CPSR_IDX_IRQ_MASK);
  assign hit          = sel_status | sel_ctrl | sel_polpair | sel_irq_stat | sel_irq_mask;

  // qualified strobes; writes land only at the access edge
  assign rd_setup    = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
  assign rd_status   = rd_en & sel_status;
  assign wr_ctrl     = wr_en & sel_ctrl;
  assign wr_irq_stat = wr_en & sel_irq_stat;
  assign wr_irq_mask = wr_en & sel_irq_mask;

  // resolved flag: forced when negotiation is off
  assign resolved = ~link_i.an_enable | link_i.an_complete; // R2 R3

  // held fields; valid only while resolved reads one
  assign fld_speed    = speed_q; // R1
  assign fld_duplex   = duplex_q; // R4
  assign fld_page     = page_q; // R5
  assign fld_resolved = resolved; // R2
  assign fld_tx_pause = tx_pause_q; // R7
  assign fld_rx_pause = rx_pause_q; // R7
  assign fld_mdix     = mdix_q; // R8

  // real-time bits bypass the holding flops
  assign fld_link     = link_i.link_up; // R6
  assign fld_sleep    = link_i.energy_sleep; // R13
  assign fld_glink    = link_i.link_up; // R10
  assign fld_jabber   = link_i.jabber; // R13

  // polarity reads normal while reversal is disabled
  assign fld_polarity = link_i.pol_rev & ~pol_dis_q; // R11

  // per-pair view shares the same disable
  assign fld_pairs    = link_i.pair_pol & {`CPSR_PAIR_W{~pol_dis_q}}; // R12

  // assemble the status word; reserved bits read zero
  always_comb begin
    status_word                                      = '0;
    status_word[`CPSR_ST_SPEED_HI:`CPSR_ST_SPEED_LO] = fld_speed;
    status_word[`CPSR_ST_DUPLEX]                     = fld_duplex;
    status_word[`CPSR_ST_PAGE]                       = fld_page;
    status_word[`CPSR_ST_RESOLVED]                   = fld_resolved;
    status_word[`CPSR_ST_LINK]                       = fld_link;
    status_word[`CPSR_ST_TX_PAUSE]                   = fld_tx_pause;
    status_word[`CPSR_ST_RX_PAUSE]                   = fld_rx_pause;
    status_word[`CPSR_ST_MDIX]                       = fld_mdix;
    status_word[`CPSR_ST_SLEEP]                      = fld_sleep;
    status_word[`CPSR_ST_GLINK]                      = fld_glink;
    status_word[`CPSR_ST_POLARITY]                   = fld_polarity;
    status_word[`CPSR_ST_JABBER]                     = fld_jabber;
  end

  // speed held from the last resolved cycle; reset shows gigabit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_q <= `CPSR_SPD_RST;
    end else if (resolved) begin
      speed_q <= link_i.speed; // R1
    end
  end

  // duplex held the same way, so a pending resolution keeps the old value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      duplex_q <= '0;
    end else if (resolved) begin
      duplex_q <= link_i.full_duplex; // R4
    end
  end

  // transmit pause is only reported; nothing inside reads it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pause_q <= '0;
    end else if (resolved) begin
      tx_pause_q <= link_i.tx_pause; // R7
    end
  end

  // receive pause, likewise informational only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_pause_q <= '0;
    end else if (resolved) begin
      rx_pause_q <= link_i.rx_pause; // R7
    end
  end

  // crossover: staged mode takes effect only on software reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xo_active_q <= `CPSR_XO_RST;
    end else if (sw_reset_i) begin
      xo_active_q <= xo_staged_q; // R9
    end
  end

  // crossover status follows manual setting or the auto resolver
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdix_q <= `CPSR_MDIX_RST; // R8
    end else if (xo_active_q == `CPSR_XO_MDIX) begin
      mdix_q <= 1'b1; // R8
    end else if (xo_active_q == `CPSR_XO_MDI) begin
      mdix_q <= 1'b0; // R8
    end else if (resolved) begin
      mdix_q <= link_i.mdix_auto; // R8
    end
  end

  // crossover mode is staged here; changing it live would disrupt the line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xo_staged_q <= `CPSR_XO_RST;
    end else if (wr_ctrl) begin
      xo_staged_q <= apb_req.pwdata[`CPSR_CTRL_XO_HI:`CPSR_CTRL_XO_LO]; // R9
    end
  end

  // polarity reversal disable acts at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_dis_q <= '0;
    end else if (wr_ctrl) begin
      pol_dis_q <= apb_req.pwdata[`CPSR_CTRL_POLDIS]; // R11
    end
  end

  // page flag: a new page beats the clearing read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q <= 1'b0;
    end else if (link_i.page_rx) begin
      page_q <= 1'b1; // R5
    end else if (rd_status) begin
      page_q <= 1'b0; // R5
    end
  end

  // previous link level for change detection; idles low like the link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_q <= '0;
    end else begin
      link_q <= link_i.link_up;
    end
  end

  // previous resolved level; low at reset so a forced resolve is an event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_resolved_q <= '0;
    end else begin
      prev_resolved_q <= resolved;
    end
  end

  // page arrival and either edge of the link
  assign irq_ev[`CPSR_IRQ_PAGE]     = link_i.page_rx;
  assign irq_ev[`CPSR_IRQ_LINK]     = link_i.link_up ^ link_q;

  // a speed change only counts once resolution stands
  assign irq_ev[`CPSR_IRQ_SPEED]    = resolved & (link_i.speed != speed_q);

  // resolution rising
  assign irq_ev[`CPSR_IRQ_RESOLVED] = resolved & ~prev_resolved_q;

  // sticky status, write one to clear; a same-cycle event wins
  for (genvar b = 0; b < `CPSR_IRQ_W; b++) begin : g_sticky
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        irq_stat_q[b] <= 1'b0;
      end else if (irq_ev[b]) begin
        irq_stat_q[b] <= 1'b1;
      end else if (wr_irq_stat && apb_req.pwdata[b]) begin
        irq_stat_q[b] <= 1'b0;
      end
    end
  end

  // mask register, one enables the source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_q <= '0;
    end else if (wr_irq_mask) begin
      irq_mask_q <= apb_req.pwdata[`CPSR_IRQ_W-1:0];
    end
  end

  // level interrupt; stays high until every unmasked bit is cleared
  assign irq_o = |(irq_stat_q & irq_mask_q);

  // read multiplexer; unmapped offsets read zero
  always_comb begin
    rd_word = '0;
    // status word in the low half
    if (sel_status) begin
      rd_word[`CPSR_ST_W-1:0] = status_word;
    end
    // staged crossover mode and polarity disable
    if (sel_ctrl) begin
      rd_word[`CPSR_CTRL_XO_HI:`CPSR_CTRL_XO_LO] = xo_staged_q;
      rd_word[`CPSR_CTRL_POLDIS]                 = pol_dis_q;
    end
    // per-pair polarity
    if (sel_polpair) begin
      rd_word[`CPSR_PAIR_W-1:0] = fld_pairs; // R12
    end
    // sticky interrupt status
    if (sel_irq_stat) begin
      rd_word[`CPSR_IRQ_W-1:0] = irq_stat_q;
    end
    // interrupt mask
    if (sel_irq_mask) begin
      rd_word[`CPSR_IRQ_W-1:0] = irq_mask_q;
    end
  end

  // read data registered at the access edge would lag; data is a flop fed ahead in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_setup) begin
      prdata <= rd_word;
    end
  end
endmodule

// file: sim/cpsr_asserts.sv
// Purpose: apb and status word checks
// Assumes: a status read setup loads prdata
// Notes:   bound onto cpsr_status
`timescale 1ns/1ns
module cpsr_asserts (
  input wire logic                    pclk,
  input wire logic                    presetn,
  input wire cpsr_pkg::cpsr_apb_req_t apb_req,
  input wire logic                    pready,
  input wire logic [31:0]             prdata,
  input wire logic                    pslverr,
  input wire cpsr_pkg::cpsr_link_t    link_i,
  input wire logic                    sw_reset_i,
  input wire logic                    irq_o
);
  import cpsr_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // status read setup; the word is seen one edge later
  wire st_rd = apb_req.psel & !apb_req.penable & !apb_req.pwrite & (apb_req.paddr == 8'h44);
  wire res   = !link_i.an_enable | link_i.an_complete;
  zero_wait_a: assert property (pready == (apb_req.psel & apb_req.penable)) else $error("late pready");
  err_phase_a: assert property (pslverr |-> apb_req.psel & apb_req.penable) else $error("stray pslverr");
  resolved_bit_a: assert property (st_rd |=> prdata[11] == $past(res)) else $error("bad resolved");
  forced_res_a: assert property (st_rd & !link_i.an_enable |=> prdata[11]) else $error("not forced");
  live_link_a:
    assert property (st_rd |=> prdata[10] == $past(link_i.link_up) && prdata[3] == prdata[10]) else $error("link");
  speed_duplex_a:
    assert property (st_rd & res |=> prdata[15:13] == {$past(link_i.speed), $past(link_i.full_duplex)})
      else $error("speed or duplex");
  pause_mirror_a:
    assert property (st_rd & res |=> prdata[9:8] == {$past(link_i.tx_pause), $past(link_i.rx_pause)})
      else $error("pause bits");
  sleep_jabber_a:
    assert property (st_rd |=> {prdata[4], prdata[0]} == {$past(link_i.energy_sleep), $past(link_i.jabber)})
      else $error("sleep or jabber");
  // set wins over the clearing read, so one cycle later the flag must show
  page_latch_a: assert property (link_i.page_rx ##1 st_rd |=> prdata[12]) else $error("page lost");
endmodule
bind cpsr_status cpsr_asserts cpsr_asserts_inst (.pclk, .presetn, .apb_req, .pready, .prdata, .pslverr,
                                                 .link_i, .sw_reset_i, .irq_o);

// file: sim/cpsr_link_model.sv
// Purpose: negotiation and line logic in front of the status word
// Assumes: fields settle together one clock after a request
// Notes:   resets with negotiation on and pending, as after power up
`timescale 1ns/1ns
module cpsr_link_model (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire cpsr_pkg::cpsr_link_t want,
  output cpsr_pkg::cpsr_link_t      link_o
);
  import cpsr_pkg::*;
  // registered so no field glitches apart from the others
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) link_o <= 17'h10000;
    else link_o <= want;
  end
endmodule

// file: sim/cpsr_status_test.sv
// Purpose: self-checking bench for cpsr_status
// Assumes: zero-wait apb slave, link view from cpsr_link_model
// Notes:   sp..mx hold what the word keeps while unresolved
`timescale 1ns/1ns
module cpsr_status_test;
  import cpsr_pkg::*;
  logic          pclk = 0, presetn = 0, sw_rst = 0, pready, pslverr, irq, perr, pd = 0;
  logic          dp = 0, tp = 0, rp = 0, mx = 1;
  logic [1:0]    sp = 2'h2, xm [2] = '{2'h0, 2'h1};
  logic [31:0]   prdata, got, rv [5] = '{32'h8040, 32'h60, 32'h0, 32'h0, 32'h0};
  logic [7:0]    adr [5] = '{8'h44, 8'h40, 8'h54, 8'h80, 8'h84};
  cpsr_apb_req_t req = '0;
  cpsr_link_t    w = 17'h10000, v, link;
  int            err_total = 0, checks_done = 0, cyc = 0;
  always #4 pclk = ~pclk;
  cpsr_link_model cpsr_link_model_inst (.pclk, .presetn, .want(w), .link_o(link));
  cpsr_status cpsr_status_inst (.pclk, .presetn, .apb_req(req), .pready, .prdata, .pslverr,
                                .link_i(link), .sw_reset_i(sw_rst), .irq_o(irq));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  // one transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    got = prdata;
    perr = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  // expected word from the live view and the held fields
  function automatic logic [31:0] st(input logic pg);
    st = {16'h0, sp, dp, pg, !w.an_enable | w.an_complete, w.link_up, tp, rp, 1'b0, mx, 1'b0,
          w.energy_sleep, w.link_up, 1'b0, w.pol_rev & !pd, w.jabber};
  endfunction
  task automatic put(input cpsr_link_t n);
    w <= n;
    repeat (3) @(posedge pclk);
    if (!n.an_enable | n.an_complete) {sp, dp, tp, rp, mx} = {n.speed, n.full_duplex, n.tx_pause, n.rx_pause,
                                                              n.mdix_auto};
  endtask
  task automatic page(input int n);
    w.page_rx <= 1'b1;
    @(posedge pclk);
    w.page_rx <= 1'b0;
    repeat (n) @(posedge pclk);
  endtask
  // hang guard: the run needs a few hundred cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish;
    end
  end
  initial begin
    void'($urandom(32'h04fd));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (adr[i]) begin
      apb(0, adr[i], 0);
      chk("reset", got, rv[i]);
    end
    apb(1, 8'h0c, 1);
    chk("unmapped", perr, 1);
    $display("test reset done");
    repeat (30) begin
      v = cpsr_link_t'($urandom);
      v.page_rx = 1'b0;
      put(v);
      apb(0, 8'h44, 0);
      chk("status", got, st(0));
      apb(0, 8'h54, 0);
      chk("pairs", got, {28'h0, v.pair_pol});
    end
    $display("test random done");
    apb(1, 8'h80, 32'hf);
    apb(1, 8'h84, 32'h1);
    page(3);
    chk("irq", irq, 1);
    apb(0, 8'h44, 0);
    chk("page set", got, st(1));
    apb(0, 8'h44, 0);
    chk("page clr", got, st(0));
    apb(1, 8'h80, 32'h1);
    @(negedge pclk);
    chk("irq clr", irq, 0);
    apb(1, 8'h84, 32'h0);
    page(0);
    apb(0, 8'h44, 0);
    chk("page next", got, st(1));
    chk("irq mask", irq, 0);
    apb(0, 8'h80, 0);
    chk("irq stat", got, 1);
    $display("test page done");
    v.pol_rev = 1'b1;
    put(v);
    apb(1, 8'h40, 32'h62);
    pd = 1'b1;
    apb(0, 8'h44, 0);
    chk("pol off", got, st(0));
    apb(0, 8'h54, 0);
    chk("pairs off", got, 0);
    pd = 1'b0;
    foreach (xm[i]) begin
      apb(1, 8'h40, {25'h0, xm[i], 5'h0});
      apb(0, 8'h44, 0);
      chk("xo staged", got, st(0));
      sw_rst <= 1'b1;
      @(posedge pclk);
      sw_rst <= 1'b0;
      mx = xm[i][0];
      repeat (2) @(posedge pclk);
      apb(0, 8'h44, 0);
      chk("xo applied", got, st(0));
    end
    $display("test crossover done");
    tally_and_finish;
  end
endmodule
